// file: hdl/vpr_pic_run_ctl.sv
// picture run command control with stream stall and results
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
module vpr_pic_run_ctl
  import vpr_pkg::*;
#(
  parameter int STRM_AW = 10,
  parameter int TICK_CYC = ENC_TICK_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic busy_o,
  output logic strm_we_o,
  output logic [STRM_AW-1:0] strm_addr_o,
  output logic [31:0] strm_data_o
);
  localparam int PW = STRM_AW + 1;
  localparam logic [PW-1:0] DEPTH = PW'(1) << STRM_AW;

  ////////////////////////////////////////////////////////////////////////
  // state
  vpr_state_e state;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;
  logic [31:0] cfg;
  logic [31:0] pic_opt;
  logic [31:0] src_y;
  logic [31:0] src_cb;
  logic [31:0] src_cr;
  logic [15:0] enc_len;
  logic [15:0] target;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [15:0] mb_cnt;
  logic [7:0] slice_mb;
  logic [15:0] slice_cnt;
  logic [PW-1:0] slice_start;
  logic [PW-1:0] pic_start;
  logic cur_skip;
  logic cur_intra;
  logic [Q_W-1:0] cur_q;
  logic cur_fmt422;
  logic first_pic;
  logic [7:0] gop_cnt;
  logic [31:0] frame_cnt;
  logic [31:0] pbuf [PB_N];
  logic [7:0] tick_cnt;
  logic tick;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  logic wr_cmd;
  logic wr_ring_rd;
  logic [7:0] cmd;
  logic cmd_run;
  logic cmd_end;
  logic cmd_rel;
  logic can_start;
  logic run_ok;
  logic end_ok;
  logic rel_ok;
  logic refused;
  logic ring;

  assign wr_cmd = wr_i && addr_i == A_CMD;
  assign cmd = wdata_i[7:0];
  assign cmd_run = wr_cmd && cmd == CMD_PIC_RUN;
  assign cmd_end = wr_cmd && cmd == CMD_END_OF_SEQUENCE_CMD;
  assign cmd_rel = wr_cmd && cmd == CMD_RELEASE;
  assign ring = cfg[CB_RING]; // [R16]
  // held results block everything except their own release
  assign can_start = state == ST_IDLE;
  assign run_ok = cmd_run & can_start; // [R13]
  assign end_ok = cmd_end & can_start; // [R13]
  assign rel_ok = cmd_rel & (state == ST_HOLD); // [R13]
  assign refused = wr_cmd & ~(run_ok | end_ok | rel_ok); // [R13]
  // pointer writes have no effect in frame mode
  assign wr_ring_rd = wr_i && addr_i == A_RD_PTR && ring; // [R11]

  ////////////////////////////////////////////////////////////////////////
  // submodules and encode pacing
  logic [Q_W-1:0] eff_q;
  logic auto_skip;
  logic chroma_rdy;
  logic enc_tick;
  logic [PW-1:0] fill;
  logic full;
  logic done;
  logic emit;
  logic [15:0] pic_words;

  assign fill = wr_ptr - rd_ptr;
  assign full = fill >= DEPTH; // [R9]
  // ticks only reach the converter while the encode may advance
  assign enc_tick = tick & (state == ST_RUN) & ~full & ~cur_skip;
  assign emit = chroma_rdy & (state == ST_RUN) & ~full; // [R9]
  assign done = (state == ST_RUN) &
                (cur_skip | (mb_cnt == enc_len)); // [R3]
  assign pic_words = cur_skip ? 16'h0 : mb_cnt;

  vpr_rate_ctl u_rate (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .clear_i(end_ok),
    .rc_en_i(cfg[CB_RC_EN]),
    .autoskip_en_i(cfg[CB_AUTOSKIP]),
    .pic_q_i(pic_opt[PO_Q_LSB +: Q_W]),
    .target_i(target),
    .pic_done_i(done),
    .pic_size_i(pic_words),
    .qstep_o(eff_q),
    .auto_skip_o(auto_skip)
  );

  vpr_chroma_conv u_chroma (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .start_i(run_ok),
    .tick_i(enc_tick),
    .fmt422_i(cur_fmt422),
    .chroma_rdy_o(chroma_rdy)
  );

  // encode rate enable: one pulse every TICK_CYC clocks
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tick_cnt <= 8'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 8'(TICK_CYC - 1);
      tick_cnt <= (tick_cnt == 8'(TICK_CYC - 1)) ? 8'h0 :
                  tick_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // picture type decision
  logic [7:0] gop_len;
  logic intra_due;
  logic skip_now;

  assign gop_len = cfg[CB_GOP_LSB +: 8];
  assign intra_due = first_pic |
                     (gop_len != 8'h0 && gop_cnt >= gop_len - 8'h01);
  // forced skip beats every other decision
  assign skip_now = pic_opt[PO_SKIP] | auto_skip; // [R3] [R15]

  ////////////////////////////////////////////////////////////////////////
  // control state machine
  vpr_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (done) begin
          next_state = ST_HOLD;
        end else if (full) begin
          next_state = ST_STALL; // [R9]
        end
      end
      ST_STALL: begin
        if (!full) begin
          next_state = ST_RUN; // [R9]
        end
      end
      ST_HOLD: begin
        if (rel_ok) begin
          next_state = ST_IDLE; // [R13]
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-picture latch and encode progress
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cur_skip <= 1'b0;
      cur_intra <= 1'b0;
      cur_q <= Q_INIT;
      cur_fmt422 <= 1'b0;
      mb_cnt <= 16'h0;
      slice_mb <= 8'h0;
      slice_cnt <= 16'h0;
      slice_start <= '0;
      pic_start <= '0;
    end else if (run_ok) begin
      cur_skip <= skip_now; // [R3]
      cur_intra <= pic_opt[PO_INTRA] | intra_due; // [R4]
      cur_q <= eff_q; // [R2]
      cur_fmt422 <= pic_opt[PO_FMT422]; // [R5]
      mb_cnt <= 16'h0;
      slice_mb <= 8'h0;
      slice_cnt <= 16'h0;
      slice_start <= ring ? wr_ptr : '0;
      pic_start <= ring ? wr_ptr : '0;
    end else if (emit) begin
      mb_cnt <= mb_cnt + 16'h01;
      // a new slice opens at each slice-size macroblock boundary
      if (slice_mb == 8'h0) begin
        slice_cnt <= slice_cnt + 16'h01;
        slice_start <= wr_ptr;
      end
      slice_mb <= (slice_mb + 8'h01 >= cfg[CB_SLICE_LSB +: 8]) ?
                  8'h0 : slice_mb + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stream pointers: frame mode restarts at the buffer base
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (run_ok && !ring) begin
      wr_ptr <= '0; // [R16]
      rd_ptr <= '0;
    end else begin
      if (emit) begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (wr_ring_rd) begin
        rd_ptr <= wdata_i[PW-1:0]; // [R9]
      end
    end
  end

  // stream word: quantiser and macroblock index
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      strm_we_o <= 1'b0;
      strm_addr_o <= '0;
      strm_data_o <= 32'h0;
    end else begin
      strm_we_o <= emit;
      strm_addr_o <= wr_ptr[STRM_AW-1:0];
      strm_data_o <= {cur_intra, 9'h0, cur_q, mb_cnt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // picture type history
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || end_ok) begin
      first_pic <= 1'b1;
      gop_cnt <= 8'h0;
      frame_cnt <= 32'h0;
    end else if (done) begin
      frame_cnt <= frame_cnt + 32'h1;
      if (!cur_skip) begin
        first_pic <= 1'b0;
        gop_cnt <= cur_intra ? 8'h0 : gop_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter buffer: whole layout written in the completion cycle
  logic [31:0] res [PB_N];

  assign res[PB_TYPE] = {30'h0, cur_skip ? PT_SKIP :
                         (cur_intra ? PT_I : PT_P)};
  assign res[PB_START] = 32'(pic_start[STRM_AW-1:0]) << 2;
  assign res[PB_SIZE] = 32'(pic_words) << 2;
  assign res[PB_SLICES] = {16'h0, slice_cnt};
  assign res[PB_SLICE_BND] = 32'(slice_start[STRM_AW-1:0]) << 2;
  assign res[PB_MB_BND] = 32'(wr_ptr[STRM_AW-1:0]) << 2;
  assign res[PB_QP] = {26'h0, cur_q};
  assign res[PB_FRAME] = frame_cnt;

  for (genvar gi = 0; gi < PB_N; gi++) begin : g_pbuf
    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        pbuf[gi] <= 32'h0;
      end else if (done) begin
        pbuf[gi] <= res[gi]; // [R12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      int_en <= '0;
      cfg <= 32'h0;
      pic_opt <= 32'h0;
      src_y <= 32'h0;
      src_cb <= 32'h0;
      src_cr <= 32'h0;
      enc_len <= 16'h0;
      target <= 16'h0;
    end else if (wr_i) begin
      if (addr_i == A_INT_EN) int_en <= wdata_i[INT_W-1:0]; // [R8]
      if (addr_i == A_CFG) cfg <= wdata_i;
      if (addr_i == A_PIC_OPT) pic_opt <= wdata_i;
      if (addr_i == A_SRC_Y) src_y <= wdata_i;
      if (addr_i == A_SRC_CB) src_cb <= wdata_i;
      if (addr_i == A_SRC_CR) src_cr <= wdata_i;
      if (addr_i == A_ENC_LEN) enc_len <= wdata_i[15:0];
      if (addr_i == A_TARGET) target <= wdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a clear in the same cycle
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  logic [INT_W-1:0] next_int_stat;
  logic stall_rise;

  assign stall_rise = (state == ST_RUN) & full & ~done;
  assign int_set = {done, stall_rise, end_ok, refused}; // [R7]
  assign int_clr = (wr_i && addr_i == A_INT_CLR) ?
                   wdata_i[INT_W-1:0] : '0;
  assign next_int_stat = (int_stat & ~int_clr) | int_set;

  // busy falls in the cycle the completion bit goes pending
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      int_stat <= '0;
      irq_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq_o <= |(next_int_stat & int_en); // [R8] [R17]
      if (run_ok) begin
        busy_o <= 1'b1; // [R17]
      end else if (done) begin
        busy_o <= 1'b0; // [R7] [R17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; frame mode pointer queries read as zero
  logic pb_hit;
  logic [31:0] status_w;
  logic [31:0] rd_val;

  assign pb_hit = addr_i[7:5] == A_PBUF_HI;
  assign status_w = {29'h0, state == ST_STALL, state == ST_HOLD,
                     busy_o};
  assign rd_val =
    pb_hit ? pbuf[addr_i[4:2]] :
    addr_i == A_STATUS ? status_w :
    addr_i == A_INT_STAT ? 32'(int_stat) :
    addr_i == A_INT_EN ? 32'(int_en) :
    addr_i == A_CFG ? cfg :
    addr_i == A_PIC_OPT ? pic_opt :
    addr_i == A_SRC_Y ? src_y :
    addr_i == A_SRC_CB ? src_cb :
    addr_i == A_SRC_CR ? src_cr :
    addr_i == A_ENC_LEN ? {16'h0, enc_len} :
    addr_i == A_TARGET ? {16'h0, target} :
    addr_i == A_RD_PTR && ring ? 32'(rd_ptr) : // [R11]
    addr_i == A_WR_PTR && ring ? 32'(wr_ptr) : // [R11]
    32'h0;

  // data stand one cycle after the read strobe only
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= rd_i ? rd_val : 32'h0;
    end
  end
endmodule : vpr_pic_run_ctl

// file: hdl/vpr_pkg.sv
// constants, register map and types for picture run control
// Operation
// (R1) host loads picture addresses, options, format first
// (R2) picture qstep used only without rate control
// (R3) forced skip skips picture unconditionally
// (R4) forced intra encodes picture as intra
// (R5) 4:2:2 vertical source merged to 4:2:0
// (R6) host issues run after parameters; begins only
// (R7) completion seen by busy flag or interrupt
// (R8) run completion interrupt enabled by bit 3
// (R9) full stream buffer stalls until space freed
// (R10) host drains ring buffer during encode
// (R11) frame mode ignores read pointer access
// (R12) results written to parameter buffer layout
// (R13) new commands refused until results released
// (R14) host ends instance with end of sequence
// (R15) rate control may skip pictures itself
// (R16) ring mode per instance, else frame mode
// (R17) busy clears when completion interrupt pends
package vpr_pkg;
  localparam int CLK_NS = 10;
  localparam int ENC_TICK_NS = 40;
  localparam int ENC_TICK_CYC = (ENC_TICK_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_INT_STAT = 8'h08;
  localparam logic [7:0] A_INT_CLR = 8'h0c;
  localparam logic [7:0] A_INT_EN = 8'h10;
  localparam logic [7:0] A_CFG = 8'h14;
  localparam logic [7:0] A_PIC_OPT = 8'h18;
  localparam logic [7:0] A_SRC_Y = 8'h1c;
  localparam logic [7:0] A_SRC_CB = 8'h20;
  localparam logic [7:0] A_SRC_CR = 8'h24;
  localparam logic [7:0] A_ENC_LEN = 8'h28;
  localparam logic [7:0] A_RD_PTR = 8'h2c;
  localparam logic [7:0] A_WR_PTR = 8'h30;
  localparam logic [7:0] A_TARGET = 8'h34;
  localparam logic [2:0] A_PBUF_HI = 3'h2; // 0x40..0x5c

  // command codes
  localparam logic [7:0] CMD_PIC_RUN = 8'h01;
  localparam logic [7:0] CMD_END_OF_SEQUENCE_CMD = 8'h02;
  localparam logic [7:0] CMD_RELEASE = 8'h03;

  // interrupt bits
  localparam int INT_W = 4;
  localparam int IB_REFUSED = 0;
  localparam int IB_END_OF_SEQUENCE_CMD = 1;
  localparam int IB_STALL = 2;
  localparam int IB_PIC_DONE = 3;

  // status and configuration fields
  localparam int SB_BUSY = 0;
  localparam int SB_HOLD = 1;
  localparam int SB_STALL = 2;
  localparam int CB_RC_EN = 0;
  localparam int CB_RING = 1;
  localparam int CB_AUTOSKIP = 2;
  localparam int CB_GOP_LSB = 8;
  localparam int CB_SLICE_LSB = 16;
  localparam int PO_Q_LSB = 0;
  localparam int PO_SKIP = 8;
  localparam int PO_INTRA = 9;
  localparam int PO_FMT422 = 10;
  localparam int Q_W = 6;

  // picture types and parameter buffer layout
  localparam logic [1:0] PT_I = 2'h0;
  localparam logic [1:0] PT_P = 2'h1;
  localparam logic [1:0] PT_SKIP = 2'h2;
  localparam int PB_TYPE = 0;
  localparam int PB_START = 1;
  localparam int PB_SIZE = 2;
  localparam int PB_SLICES = 3;
  localparam int PB_SLICE_BND = 4;
  localparam int PB_MB_BND = 5;
  localparam int PB_QP = 6;
  localparam int PB_FRAME = 7;
  localparam int PB_N = 8;

  // rate control qstep limits
  localparam logic [Q_W-1:0] Q_INIT = 6'h10;
  localparam logic [Q_W-1:0] Q_MIN = 6'h01;
  localparam logic [Q_W-1:0] Q_MAX = 6'h1f;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_STALL = 4'b0100,
    ST_HOLD = 4'b1000
  } vpr_state_e;
endpackage : vpr_pkg

// file: hdl/vpr_chroma_conv.sv
// chroma line merge from 4:2:2 vertical to 4:2:0
`timescale 1ns/100ps
module vpr_chroma_conv
  import vpr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic fmt422_i,
  output logic chroma_rdy_o
);
  logic phase;

  // 4:2:2 carries two chroma lines per 4:2:0 line: fetch both, emit one
  // phase marks the second line of a merged pair
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      phase <= 1'b0;
      chroma_rdy_o <= 1'b0;
    end else begin
      chroma_rdy_o <= tick_i & (~fmt422_i | phase); // [R5]
      if (start_i) begin
        phase <= 1'b0;
      end else if (tick_i & fmt422_i) begin
        phase <= ~phase; // [R5]
      end
    end
  end
endmodule : vpr_chroma_conv

// file: hdl/vpr_rate_ctl.sv
// rate control: virtual buffer level, qstep and auto skip
`timescale 1ns/100ps
module vpr_rate_ctl
  import vpr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic rc_en_i,
  input wire logic autoskip_en_i,
  input wire logic [Q_W-1:0] pic_q_i,
  input wire logic [15:0] target_i,
  input wire logic pic_done_i,
  input wire logic [15:0] pic_size_i,
  output logic [Q_W-1:0] qstep_o,
  output logic auto_skip_o
);
  logic [17:0] level;
  logic [Q_W-1:0] rc_q;
  logic [17:0] sum_w;
  logic [17:0] next_level;

  assign sum_w = level + {2'h0, pic_size_i};
  assign next_level = (sum_w > {2'h0, target_i}) ?
                      sum_w - {2'h0, target_i} : 18'h0;
  // the picture qstep only counts with rate control off
  assign qstep_o = rc_en_i ? rc_q : pic_q_i; // [R2]
  // skip when the level runs past twice the per-picture target
  assign auto_skip_o = rc_en_i & autoskip_en_i &
                       (level > {1'b0, target_i, 1'b0}); // [R15]

  // level and qstep move once per finished picture
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || clear_i) begin
      level <= 18'h0;
      rc_q <= Q_INIT;
    end else if (pic_done_i) begin
      level <= next_level;
      if (pic_size_i > target_i && rc_q < Q_MAX) begin
        rc_q <= rc_q + 6'h01;
      end else if (pic_size_i < target_i && rc_q > Q_MIN) begin
        rc_q <= rc_q - 6'h01;
      end
    end
  end
endmodule : vpr_rate_ctl

// file: sim/vpr_run_chk.sv
// port-level checks for picture run control
`timescale 1ns/100ps
module vpr_run_chk
  import vpr_pkg::*;
#(
  parameter int STRM_AW = 10
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic busy_o,
  input wire logic strm_we_o,
  input wire logic [STRM_AW-1:0] strm_addr_o,
  input wire logic [31:0] strm_data_o
);
  logic [3:0] en;
  logic [10:0] po;
  logic [1:0] cfg;
  logic held;
  logic busy_q;
  logic [STRM_AW:0] wp;
  logic [STRM_AW:0] rp;
  // held also covers the cycle busy falls, before the shadow flop catches up
  wire wcmd = wr_i && addr_i == A_CMD && wdata_i[7:0] == CMD_PIC_RUN;
  wire hold_w = held || (busy_q && !busy_o);
  wire run_ok = wcmd && !busy_o && !hold_w;
  wire run_bad = wcmd && hold_w;
  wire [STRM_AW:0] fill = wp - rp;

  ////////////////////////////////////////////////////////////////////////
  // shadow of host settings and stream pointers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      en <= '0;
      po <= '0;
      cfg <= '0;
      held <= 1'b0;
      busy_q <= 1'b0;
      wp <= '0;
      rp <= '0;
    end else begin
      busy_q <= busy_o;
      if (wr_i && addr_i == A_INT_EN)
        en <= wdata_i[3:0];
      if (wr_i && addr_i == A_PIC_OPT)
        po <= wdata_i[10:0];
      if (wr_i && addr_i == A_CFG)
        cfg <= wdata_i[1:0];
      if (wr_i && addr_i == A_CMD && wdata_i[7:0] == CMD_RELEASE)
        held <= 1'b0;
      else if (busy_q && !busy_o)
        held <= 1'b1;
      if (run_ok && !cfg[CB_RING])
        wp <= '0;
      else if (strm_we_o)
        wp <= wp + (STRM_AW+1)'(1);
      if (run_ok && !cfg[CB_RING])
        rp <= '0;
      else if (wr_i && addr_i == A_RD_PTR && cfg[CB_RING])
        rp <= wdata_i[STRM_AW:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_RUN_BUSY: assert property (run_ok |=> busy_o)
    else $error("run accepted without busy");
  AST_HELD_REFUSE: assert property (run_bad |=> !busy_o)
    else $error("run taken while results held");
  AST_SKIP_ONE: assert property (
    run_ok && po[PO_SKIP] |=> busy_o ##1 !busy_o)
    else $error("skipped picture not done in one cycle");
  AST_IRQ_DONE: assert property (
    $fell(busy_o) && en[3] |-> ##[0:1] irq_o)
    else $error("no interrupt at completion");
  AST_IRQ_MASK: assert property ((en == 4'h0) [*2] |-> !irq_o)
    else $error("interrupt with all enables off");
  AST_Q_FIXED: assert property (
    strm_we_o && !cfg[CB_RC_EN] |-> strm_data_o[21:16] == po[5:0])
    else $error("picture qstep not used");
  AST_INTRA: assert property (
    strm_we_o && po[PO_INTRA] |-> strm_data_o[31])
    else $error("forced intra ignored");
  AST_GAP_422: assert property (
    strm_we_o && po[PO_FMT422] |=> !strm_we_o [*7])
    else $error("vertical 4:2:2 word spacing short");
  AST_GAP_420: assert property (strm_we_o |=> !strm_we_o [*3])
    else $error("word spacing short");
  AST_FULL: assert property (
    strm_we_o && cfg[CB_RING] |-> !fill[STRM_AW])
    else $error("word written into full buffer");
  AST_ADDR: assert property (
    strm_we_o |-> strm_addr_o == wp[STRM_AW-1:0])
    else $error("stream address out of order");
  AST_FRAME_PTR: assert property (
    rd_i && addr_i == A_RD_PTR && !cfg[CB_RING] |=> rdata_o == 32'h0)
    else $error("read pointer visible in frame mode");

  // main scenarios reached
  cover property (run_bad);
  cover property (cfg[CB_RING] && fill[STRM_AW]);
  cover property ($fell(busy_o) && irq_o);
  cover property (strm_we_o && po[PO_FMT422]);
endmodule : vpr_run_chk

bind vpr_pic_run_ctl vpr_run_chk #(.STRM_AW(STRM_AW)) u_vpr_run_chk (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .irq_o(irq_o),
  .busy_o(busy_o),
  .strm_we_o(strm_we_o),
  .strm_addr_o(strm_addr_o),
  .strm_data_o(strm_data_o)
);

// file: sim/vpr_strm_host.sv
// host side stream buffer: stores encoded words for later draining
`timescale 1ns/100ps
module vpr_strm_host #(
  parameter int STRM_AW = 3
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic strm_we_i,
  input wire logic [STRM_AW-1:0] strm_addr_i,
  input wire logic [31:0] strm_data_i,
  output logic [31:0] word_cnt_o,
  output logic [31:0] last_word_o
);
  logic [31:0] mem [2**STRM_AW];
  logic [STRM_AW-1:0] last_addr;

  // newest word read back from its slot, so a bad address shows up
  assign last_word_o = mem[last_addr];
  // words stay here until a later word is written to the same slot
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      word_cnt_o <= 32'h0;
      last_addr <= '0;
    end else if (strm_we_i) begin
      mem[strm_addr_i] <= strm_data_i;
      word_cnt_o <= word_cnt_o + 32'h1;
      last_addr <= strm_addr_i;
    end
  end
endmodule : vpr_strm_host

// file: sim/vpr_pic_run_ctl_tb.sv
// self-checking bench for picture run control
`timescale 1ns/100ps
module vpr_pic_run_ctl_tb import vpr_pkg::*;;
  localparam int AW = 3;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic busy_o;
  logic strm_we_o;
  logic [AW-1:0] strm_addr_o;
  logic [31:0] strm_data_o;
  logic [31:0] word_cnt;
  logic [31:0] last_word;
  logic [31:0] seed = 32'h569d;
  logic first = 1'b1;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  always #5 core_clk_i = ~core_clk_i;

  vpr_pic_run_ctl #(.STRM_AW(AW)) u_vpr_pic_run_ctl (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .busy_o(busy_o), .strm_we_o(strm_we_o),
    .strm_addr_o(strm_addr_o), .strm_data_o(strm_data_o));
  vpr_strm_host #(.STRM_AW(AW)) u_vpr_strm_host (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .strm_we_i(strm_we_o),
    .strm_addr_i(strm_addr_o), .strm_data_i(strm_data_o),
    .word_cnt_o(word_cnt), .last_word_o(last_word));

  ////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [1:0] f_type(logic sk, logic in, logic fs);
    return sk ? PT_SKIP : ((in || fs) ? PT_I : PT_P);
  endfunction : f_type
  function automatic logic [7:0] pb(int i);
    return 8'(64 + 4 * i);
  endfunction : pb
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // register bus master: one-cycle strobes, read data the cycle after
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // one picture: parameters first, run, drain on stall, results, release
  task automatic pic(logic [10:0] o, logic [15:0] n, logic rc, logic ring,
                     logic [3:0] en);
    logic [31:0] d;
    logic [31:0] c0 = word_cnt;
    logic [1:0] ty = f_type(o[PO_SKIP], o[PO_INTRA], first);
    logic [5:0] q = rc ? Q_INIT : o[5:0];
    logic st = 1'b0;
    int k = 0;
    wr(A_INT_EN, 32'(en));
    wr(A_PIC_OPT, 32'(o));
    wr(A_SRC_Y, c0);
    wr(A_SRC_CB, c0 + 32'h100);
    wr(A_SRC_CR, c0 + 32'h180);
    rd(A_SRC_CR, d);
    chk("src_cr", d, c0 + 32'h180);
    wr(A_ENC_LEN, 32'(n));
    wr(A_CMD, 32'(CMD_PIC_RUN));
    #1;
    chk("busy", 32'(busy_o), 32'h1);
    while (busy_o !== 1'b0 && k < 5000) begin
      k++;
      rd(A_STATUS, d);
      if (d[SB_STALL] && ring) begin
        if (!st)
          chk("stall_words", word_cnt - c0, 32'(1 << AW));
        st = 1'b1;
        wr(A_RD_PTR, word_cnt);
      end
    end
    chk("done", 32'(k < 5000), 32'h1);
    rd(A_INT_STAT, d);
    chk("int_stat", d, {28'h0, 1'b1, st, 2'b0});
    chk("irq", 32'(irq_o), 32'(en[IB_PIC_DONE]));
    rd(pb(PB_TYPE), d);
    chk("type", d, 32'(ty));
    chk("words", word_cnt - c0, o[PO_SKIP] ? 32'h0 : 32'(n));
    if (!o[PO_SKIP]) begin
      rd(pb(PB_SIZE), d);
      chk("size", d, 32'(n) * 4);
      rd(pb(PB_SLICES), d);
      chk("slices", d, 32'(n));
      rd(pb(PB_QP), d);
      chk("pb_q", d, 32'(q));
      chk("word_q", 32'(last_word[21:16]), 32'(q));
      chk("word_intra", 32'(last_word[31]), 32'(ty == PT_I));
      first = 1'b0;
    end
    wr(A_CMD, 32'(CMD_PIC_RUN));
    #1;
    chk("refused_busy", 32'(busy_o), 32'h0);
    rd(A_STATUS, d);
    chk("held", 32'(d[2:0]), 32'h2);
    rd(A_INT_STAT, d);
    chk("refused", 32'(d[IB_REFUSED]), 32'h1);
    wr(A_INT_CLR, 32'hf);
    wr(A_CMD, 32'(CMD_RELEASE));
    rd(A_STATUS, d);
    chk("released", 32'(d[2:0]), 32'h0);
    chk("irq_clr", 32'(irq_o), 32'h0);
  endtask : pic

  // hang guard, far beyond the under 1500 cycles the run needs
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // main sequence: registers, ring stall, random pictures, corners
  initial begin
    logic [31:0] d;
    logic [10:0] o;
    repeat (6) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(A_INT_STAT, d);
    chk("int_stat_rst", d, 32'h0);
    void'(rnd());
    wr(A_INT_EN, seed);
    rd(A_INT_EN, d);
    chk("int_en", d, seed & 32'hf);
    rd(8'h3c, d);
    chk("unmapped", d, 32'h0);
    wr(A_CFG, 32'h2);
    pic(11'(rnd() & 32'h3f | 32'h1), 16'd12, 1'b0, 1'b1, 4'h8);
    wr(A_CFG, 32'h0);
    wr(A_RD_PTR, 32'h5);
    rd(A_RD_PTR, d);
    chk("frame_rd_ptr", d, 32'h0);
    rd(A_WR_PTR, d);
    chk("frame_wr_ptr", d, 32'h0);
    pic(11'h601, 16'd7, 1'b0, 1'b0, 4'h8);
    pic(11'h305, 16'd3, 1'b0, 1'b0, 4'h0);
    for (int i = 0; i < 8; i++) begin
      o = 11'(rnd() & 32'h73f);
      pic(o, 16'(rnd() % 8 + 1), 1'b0, 1'b0, 4'(rnd() & 32'h8));
    end
    wr(A_CMD, 32'(CMD_END_OF_SEQUENCE_CMD));
    rd(A_INT_STAT, d);
    chk("end_of_sequence_cmd", d, 32'h2);
    wr(A_INT_CLR, 32'hf);
    first = 1'b1;
    wr(A_CFG, 32'h5); // autoskip on, level still zero
    pic(11'h005, 16'd4, 1'b1, 1'b0, 4'h8);
    summarize();
  end
endmodule : vpr_pic_run_ctl_tb
